// ---- rtl/sfm_defines.svh ----
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH

// Register offsets (7-bit serial address)
`define SFM_OFF_FLAGS 7'h0D
`define SFM_OFF_MASKS 7'h0E

// Flag and mask bit positions
`define SFM_BIT_UV 4
`define SFM_BIT_CLK 3
`define SFM_BIT_OT 2
`define SFM_BIT_OPEN 1
`define SFM_BIT_SHORT 0

// Reset values, cleared flags and the all-masked pattern
`define SFM_FLAG_RESET 5'h10
`define SFM_MASK_RESET 5'h04
`define SFM_FLAG_ZERO 5'h00
`define SFM_ALL_MASKED 5'h1F
// Pin synchroniser rest value: select high, clock low, no strap set.
// Resting with select low would fake a frame end, and so a count error, right after reset.
`define SFM_PIN_IDLE 5'h08
// Arbitrary neutral identification value
`define SFM_CHIP_ID 3'h5

// Serial frame layout
`define SFM_LEN_CRC 10'h018
`define SFM_LEN_PLAIN 10'h010
`define SFM_HDR_LAST 10'h007
`define SFM_HDR_BITS 10'h008
`define SFM_CNT_ONE 10'h001
`define SFM_CNT_ZERO 10'h000
`define SFM_CNT_MAX 10'h3FF
`define SFM_WR_BIT 7

`endif

// ---- rtl/sfm_fault_regs.sv ----
`timescale 1ns/1ps
`include "sfm_defines.svh"
module sfm_fault_regs (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Serial port
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic sdo_o,
    output logic sdo_oe_n_o,
    // Mode straps
    input wire logic daisy_mode_i,
    input wire logic crc_enable_i,
    // Analog fault sources
    input wire logic supply_low_i,
    input wire logic over_temp_i,
    input wire logic ref_open_i,
    input wire logic ref_short_i,
    // Global configuration bits
    input wire logic ref_short_detect_enable_i,
    input wire logic fault_clear_policy_i,
    input wire logic primary_read_i,
    // Fault outputs
    output logic secondary_fault_summary_o,
    output logic channels_enable_o,
    output logic system_shutdown_o
);
    import sfm_pkg::*;

    sfm_frame_if frame ();

    sfm_frame_rx u_rx (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .mosi_i(mosi_i),
        .daisy_mode_i(daisy_mode_i),
        .crc_enable_i(crc_enable_i),
        .frame(frame)
    );

    // Order: supply, temp, open, short
    logic [3:0] src_meta;
    logic [3:0] src;
    sfm_flags_t flags;
    sfm_flags_t next_flags;
    sfm_flags_t mask;
    sfm_flags_t next_mask;
    sfm_byte_t sdo_byte;
    sfm_byte_t next_sdo_byte;
    logic next_sdo;
    logic next_sdo_oe_n;
    logic next_summary;
    logic next_chan_en;
    logic unmasked_any;
    logic clear_read;
    logic short_seen;
    logic clk_err;
    logic [15:0] cmd;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            src_meta <= 4'h0;
            src <= 4'h0;
        end else begin
            src_meta <= {supply_low_i, over_temp_i, ref_open_i, ref_short_i};
            src <= src_meta;
        end
    end

    function automatic sfm_byte_t read_data(input logic [6:0] addr, input sfm_flags_t f,
        input sfm_flags_t m);
        if (addr == `SFM_OFF_FLAGS) begin
            return {3'h0, f};
        end
        if (addr == `SFM_OFF_MASKS) begin
            return {`SFM_CHIP_ID, m};
        end
        return 8'h00;
    endfunction : read_data

    assign frame.spi_off = src[2];
    assign cmd = frame.crc_en ? frame.shift[23:8] : frame.shift[15:0];
    assign short_seen = src[0] && ref_short_detect_enable_i;
    assign clk_err = frame.done && !frame.ok;
    assign clear_read = frame.done && frame.ok && !cmd[8 + `SFM_WR_BIT]
        && (cmd[14:8] == `SFM_OFF_FLAGS);
    assign unmasked_any = |(flags & ~mask);

    always_comb begin
        sfm_flags_t set;
        set = '0;
        set[`SFM_BIT_UV] = src[3];
        set[`SFM_BIT_CLK] = clk_err;
        set[`SFM_BIT_OT] = src[2];
        set[`SFM_BIT_OPEN] = src[1] || src[2];
        set[`SFM_BIT_SHORT] = short_seen;
        next_flags = (clear_read ? `SFM_FLAG_ZERO : flags) | set;
        if (!ref_short_detect_enable_i) begin
            next_flags[`SFM_BIT_SHORT] = flags[`SFM_BIT_SHORT];
        end
        next_mask = mask;
        if (frame.done && frame.ok && cmd[8 + `SFM_WR_BIT] && (cmd[14:8] == `SFM_OFF_MASKS)) begin
            next_mask = cmd[4:0];
        end
        if (!fault_clear_policy_i) begin
            next_summary = unmasked_any;
        end else begin
            next_summary = unmasked_any || (secondary_fault_summary_o && !primary_read_i);
        end
        next_chan_en = !src[2] && !short_seen;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            flags <= `SFM_FLAG_RESET;
            mask <= `SFM_MASK_RESET;
            secondary_fault_summary_o <= 1'b0;
            channels_enable_o <= 1'b0;
            system_shutdown_o <= 1'b0;
        end else begin
            flags <= next_flags;
            mask <= next_mask;
            secondary_fault_summary_o <= next_summary;
            channels_enable_o <= next_chan_en;
            system_shutdown_o <= src[2];
        end
    end

    // Daisy mode passes bits through one frame late; reads answer only when addressed
    always_comb begin
        sfm_count_t len;
        len = frame.crc_en ? `SFM_LEN_CRC : `SFM_LEN_PLAIN;
        next_sdo = sdo_o;
        next_sdo_byte = sdo_byte;
        next_sdo_oe_n = !frame.active;
        if (!frame.active) begin
            next_sdo = 1'b0;
        end else if (frame.daisy) begin
            if (frame.sclk_fall) begin
                next_sdo = frame.shift[len[4:0] - 5'h01];
            end
        end else if (frame.hdr_ready) begin
            next_sdo_byte = read_data(frame.shift[6:0], flags, mask);
        end else if (frame.sclk_fall && frame.bit_cnt >= `SFM_HDR_BITS) begin
            next_sdo = sdo_byte[7];
            next_sdo_byte = {sdo_byte[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sdo_o <= 1'b0;
            sdo_oe_n_o <= 1'b1;
            sdo_byte <= 8'h00;
        end else begin
            sdo_o <= next_sdo;
            sdo_oe_n_o <= next_sdo_oe_n;
            sdo_byte <= next_sdo_byte;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    a_uv_flag_set: assert property (src[3] |=> flags[`SFM_BIT_UV])
        else $error("undervoltage flag not set");
    a_clk_err_flag: assert property (clk_err |=> flags[`SFM_BIT_CLK])
        else $error("clock count error not flagged");
    a_bad_frame_ignored: assert property (clk_err |=> $stable(mask))
        else $error("bad frame changed mask");
    a_thermal_flag: assert property (src[2] |=> flags[`SFM_BIT_OT] && flags[`SFM_BIT_OPEN])
        else $error("thermal flags not set");
    a_shutdown_off: assert property (src[2] |=> !channels_enable_o && system_shutdown_o)
        else $error("shutdown did not disable outputs");
    a_open_no_action: assert property (src[1] && !src[2] && !short_seen
        |=> channels_enable_o)
        else $error("open circuit disabled channels");
    a_short_hold: assert property (!ref_short_detect_enable_i |=> $stable(flags[0]))
        else $error("short flag changed while disabled");
    a_short_disable: assert property (short_seen |=> !channels_enable_o ##0 flags[0])
        else $error("short did not disable channels");
    a_summary_or: assert property (!fault_clear_policy_i
        |=> secondary_fault_summary_o == $past(unmasked_any))
        else $error("summary differs from masked OR");
    a_all_masked: assert property (mask == `SFM_ALL_MASKED && !fault_clear_policy_i
        |=> !secondary_fault_summary_o)
        else $error("masked flag reached summary");
    a_mask_reset: assert property ($past(rst_i) |-> mask == `SFM_MASK_RESET)
        else $error("mask reset value wrong");
    // Short flag is held, not cleared, while its detection is off
    a_read_clears: assert property (clear_read && !src[3] && !src[2] && !src[1]
        && !short_seen |=> flags[`SFM_BIT_UV:`SFM_BIT_OPEN] == 4'h0
        && flags[`SFM_BIT_SHORT] == $past(flags[`SFM_BIT_SHORT] && !ref_short_detect_enable_i))
        else $error("read did not clear flags");
    a_id_fixed: assert property (frame.hdr_ready && frame.shift[6:0] == `SFM_OFF_MASKS
        && !frame.daisy |=> sdo_byte[7:5] == `SFM_CHIP_ID)
        else $error("identity field changed");

    c_read_clear: cover property (clear_read ##1 flags == `SFM_FLAG_ZERO);
    c_clk_error: cover property (clk_err);
    c_mask_write: cover property (frame.done && frame.ok ##1 $changed(mask));
    c_thermal: cover property (src[2] ##1 system_shutdown_o);
endmodule : sfm_fault_regs

// ---- rtl/sfm_frame_if.sv ----
`timescale 1ns/1ps
interface sfm_frame_if;
    import sfm_pkg::*;
    logic spi_off;
    logic active;
    logic sclk_fall;
    logic hdr_ready;
    logic done;
    logic ok;
    logic crc_en;
    logic daisy;
    sfm_count_t bit_cnt;
    sfm_shift_t shift;
    modport rx (input spi_off, output active, sclk_fall, hdr_ready, done, ok, crc_en, daisy,
        bit_cnt, shift);
    modport regs (output spi_off, input active, sclk_fall, hdr_ready, done, ok, crc_en,
        daisy, bit_cnt, shift);
endinterface : sfm_frame_if

// ---- rtl/sfm_frame_rx.sv ----
`timescale 1ns/1ps
`include "sfm_defines.svh"
module sfm_frame_rx (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Serial pins and mode straps
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    input wire logic daisy_mode_i,
    input wire logic crc_enable_i,
    // Frame events
    sfm_frame_if.rx frame
);
    import sfm_pkg::*;

    // Order: sclk, cs_n, mosi, daisy, crc
    logic [4:0] meta;
    logic [4:0] sync;
    logic sclk_d;
    logic cs_n_d;
    sfm_count_t cnt;
    sfm_count_t next_cnt;
    sfm_shift_t shift;
    sfm_shift_t next_shift;
    logic done;
    logic next_done;
    logic ok;
    logic next_ok;
    logic hdr;
    logic next_hdr;
    logic fall;
    logic next_fall;

    function automatic logic count_ok(input sfm_count_t n, input logic dsy, input logic crc);
        sfm_count_t len;
        len = crc ? `SFM_LEN_CRC : `SFM_LEN_PLAIN;
        if (dsy) begin
            return (n != `SFM_CNT_ZERO) && ((n % len) == `SFM_CNT_ZERO);
        end
        return n == len;
    endfunction : count_ok

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            meta <= `SFM_PIN_IDLE;
            sync <= `SFM_PIN_IDLE;
            sclk_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else begin
            meta <= {sclk_i, cs_n_i, mosi_i, daisy_mode_i, crc_enable_i};
            sync <= meta;
            sclk_d <= sync[4];
            cs_n_d <= sync[3];
        end
    end

    always_comb begin
        logic act;
        logic rise;
        act = 1'b0;
        rise = 1'b0;
        act = !sync[3] && !frame.spi_off;
        rise = act && sync[4] && !sclk_d;
        next_cnt = cnt;
        next_shift = shift;
        if (cs_n_d && !sync[3]) begin
            next_cnt = `SFM_CNT_ZERO;
        end else if (rise) begin
            next_shift = {shift[22:0], sync[2]};
            if (cnt != `SFM_CNT_MAX) begin
                next_cnt = cnt + `SFM_CNT_ONE;
            end
        end
        next_hdr = rise && (cnt == `SFM_HDR_LAST);
        next_fall = act && !sync[4] && sclk_d;
        next_done = sync[3] && !cs_n_d && !frame.spi_off;
        next_ok = next_done && count_ok(cnt, sync[1], sync[0]);
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cnt <= `SFM_CNT_ZERO;
            shift <= '0;
            done <= 1'b0;
            ok <= 1'b0;
            hdr <= 1'b0;
            fall <= 1'b0;
        end else begin
            cnt <= next_cnt;
            shift <= next_shift;
            done <= next_done;
            ok <= next_ok;
            hdr <= next_hdr;
            fall <= next_fall;
        end
    end

    assign frame.active = !sync[3] && !frame.spi_off;
    assign frame.sclk_fall = fall;
    assign frame.hdr_ready = hdr;
    assign frame.done = done;
    assign frame.ok = ok;
    assign frame.crc_en = sync[0];
    assign frame.daisy = sync[1];
    assign frame.bit_cnt = cnt;
    assign frame.shift = shift;
endmodule : sfm_frame_rx

// ---- rtl/sfm_pkg.sv ----
package sfm_pkg;
    typedef logic [4:0] sfm_flags_t;
    typedef logic [7:0] sfm_byte_t;
    typedef logic [9:0] sfm_count_t;
    typedef logic [23:0] sfm_shift_t;
endpackage : sfm_pkg

// ---- tb/secondary_fault_status_mask_tb_top.sv ----
`timescale 1ns/1ps
`include "sfm_defines.svh"
module secondary_fault_status_mask_tb_top;
    import sfm_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic sclk, cs_n, mosi, sdo, sdo_oe_n, summary, chan_en, shutdown;
    logic sdo_line;
    // An undriven data line reads back inverted, so a missing output enable spoils read data
    assign sdo_line = sdo_oe_n ? ~sdo : sdo;
    logic daisy = 1'b0, crc = 1'b0, sden = 1'b0, policy = 1'b0, pread = 1'b0, ot = 1'b0;
    // Sources: 0 undervoltage, 1 reference open, 2 reference short
    logic [2:0] src = 3'h0;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h3B22AC10;
    logic [31:0] rx;
    sfm_byte_t d;
    sfm_flags_t m;
    int pos[3] = '{4, 1, 0};
    // Per case {accepted, crc, daisy} and its clock count
    logic [2:0] kind[8] = '{3'h0, 3'h0, 3'h2, 3'h1, 3'h3, 3'h6, 3'h5, 3'h7};
    int len[8] = '{15, 24, 16, 24, 32, 24, 32, 24};

    sfm_fault_regs i_sfm_fault_regs (
        .clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
        .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .daisy_mode_i(daisy), .crc_enable_i(crc),
        .supply_low_i(src[0]), .over_temp_i(ot), .ref_open_i(src[1]),
        .ref_short_i(src[2]), .ref_short_detect_enable_i(sden),
        .fault_clear_policy_i(policy), .primary_read_i(pread),
        .secondary_fault_summary_o(summary), .channels_enable_o(chan_en),
        .system_shutdown_o(shutdown)
    );
    sfm_spi_host i_sfm_spi_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .sdo_i(sdo_line));

    always #12.5 clock_i = ~clock_i;

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            stop_test();
        end
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xorshift

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick

    task automatic rd(input logic [6:0] a);
        i_sfm_spi_host.xfer({16'h0, 1'b0, a, 8'h00}, 16, rx);
        d = rx[7:0];
    endtask : rd

    task automatic wr(input logic [7:0] v);
        i_sfm_spi_host.xfer({16'h0, 1'b1, `SFM_OFF_MASKS, v}, 16, rx);
    endtask : wr

    task automatic stop_test();
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        tick(2);
        rst_i = 1'b0;
        tick(6);
        rd(`SFM_OFF_MASKS);
        check("mask reset", d, {`SFM_CHIP_ID, `SFM_MASK_RESET});
        rd(`SFM_OFF_FLAGS);
        check("flag reset", d, {3'h0, `SFM_FLAG_RESET});
        rd(`SFM_OFF_FLAGS);
        check("flag clear", d, 8'h00);
        check("chan on", 8'(chan_en), 8'h01);
        for (int k = 0; k < 5; k++) begin
            seed = xorshift(seed);
            wr(k == 0 ? 8'hFF : seed[7:0]);
            rd(`SFM_OFF_MASKS);
            check("mask rw", d, {`SFM_CHIP_ID, k == 0 ? 5'h1F : seed[4:0]});
        end
        tick(1);
        sden = 1'b1;
        for (int b = 0; b < 3; b++) begin
            for (int mk = 0; mk < 2; mk++) begin
                m = mk ? 5'(1 << pos[b]) : 5'h00;
                wr({3'h0, m});
                rd(`SFM_OFF_FLAGS);
                tick(1);
                src[b] = 1'b1;
                tick(8);
                check("summary set", 8'(summary), 8'(mk == 0));
                check("chan gate", 8'(chan_en), 8'(b != 2));
                src[b] = 1'b0;
                tick(8);
                rd(`SFM_OFF_FLAGS);
                check("flag latch", d, 8'(1 << pos[b]));
                tick(8);
                check("summary clr", 8'(summary), 8'h00);
            end
        end
        // Short flag must hold whatever it had while detection is off
        tick(1);
        sden = 1'b0;
        src[2] = 1'b1;
        tick(8);
        rd(`SFM_OFF_FLAGS);
        check("short off", d, 8'h00);
        sden = 1'b1;
        tick(8);
        sden = 1'b0;
        src[2] = 1'b0;
        tick(8);
        for (int k = 0; k < 2; k++) begin
            rd(`SFM_OFF_FLAGS);
            check("short hold", d, 8'h01);
        end
        tick(1);
        sden = 1'b1;
        tick(8);
        rd(`SFM_OFF_FLAGS);
        for (int c = 0; c < 8; c++) begin
            tick(1);
            crc = kind[c][1];
            daisy = kind[c][0];
            tick(8);
            seed = xorshift(seed);
            i_sfm_spi_host.xfer(crc ? {8'h5A, 1'b1, `SFM_OFF_MASKS, seed[7:0], 8'h00}
                : {seed[31:16], 1'b1, `SFM_OFF_MASKS, seed[7:0]}, len[c], rx);
            if (kind[c][2]) m = seed[4:0];
            tick(1);
            crc = 1'b0;
            daisy = 1'b0;
            tick(8);
            rd(`SFM_OFF_MASKS);
            check("count mask", d, {`SFM_CHIP_ID, m});
            rd(`SFM_OFF_FLAGS);
            check("count flag", d, kind[c][2] ? 8'h00 : 8'h08);
        end
        wr(8'h1B);
        tick(1);
        ot = 1'b1;
        tick(8);
        check("shutdown", 8'(shutdown), 8'h01);
        check("chan off", 8'(chan_en), 8'h00);
        check("ot summary", 8'(summary), 8'h01);
        fork
            wr(8'h00);
            begin
                tick(40);
                check("oe off", 8'(sdo_oe_n), 8'h01);
            end
        join
        tick(1);
        ot = 1'b0;
        tick(8);
        rd(`SFM_OFF_MASKS);
        check("ot ignore", d, {`SFM_CHIP_ID, 5'h1B});
        rd(`SFM_OFF_FLAGS);
        check("ot flags", d, 8'h06);
        wr(8'h00);
        tick(1);
        policy = 1'b1;
        src[0] = 1'b1;
        tick(8);
        src[0] = 1'b0;
        tick(8);
        rd(`SFM_OFF_FLAGS);
        tick(8);
        check("sticky", 8'(summary), 8'h01);
        pread = 1'b1;
        tick(1);
        pread = 1'b0;
        tick(8);
        check("primary clr", 8'(summary), 8'h00);
        stop_test();
    end
endmodule : secondary_fault_status_mask_tb_top

// ---- tb/sfm_spi_host.sv ----
`timescale 1ns/1ps
module sfm_spi_host (
    // Serial pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic sdo_i
);
    // Clock idles low between frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // exact clock count
    // Sends tx[n-1:0] first bit highest; a wrong n is how a miscounted frame is made
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o = tx[i];
            #100;
            sclk_o = 1'b1;
            rx = {rx[30:0], sdo_i};
            #100;
            sclk_o = 1'b0;
        end
        #100;
        cs_n_o = 1'b1;
        // Released data line must not keep looking valid
        mosi_o = ~mosi_o;
        #500;
    endtask : xfer
endmodule : sfm_spi_host
